// File: rtl/drs_sample_mux_top.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Double-rate sample pair multiplexing and pass-through
// ************************************************************
module drs_sample_mux_top (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_double_rate_mode,
    input wire logic i_base_48k,
    input wire logic i_use_recovered,
    input wire logic i_rx_frame_valid,
    input wire logic [drs_pkg::FRAME_W-1:0] i_rx_frame,
    input wire logic i_cs_valid,
    input wire logic [7:0] i_cs_byte0,
    input wire logic i_tx_pro,
    input wire logic i_tx_nonaudio,
    input wire logic [2:0] i_tx_emph,
    input wire logic i_tx_copy,
    input wire logic [1:0] i_tx_hi,
    output logic o_sample_tick,
    output logic o_frame_tick,
    output logic o_rec_valid,
    output logic [drs_pkg::FRAME_W-1:0] o_rec_data,
    output logic o_tx_frame_valid,
    output logic [drs_pkg::FRAME_W-1:0] o_tx_frame,
    output logic o_overrun,
    output logic o_cs_pro,
    output logic o_cs_nonaudio,
    output logic [2:0] o_cs_emph,
    output logic o_cs_copy,
    output logic o_cs_locked,
    output logic [1:0] o_cs_hi,
    output logic [7:0] o_tx_cs_byte0
);
    localparam int W = drs_pkg::SAMPLE_W;
    localparam int N = drs_pkg::LINK_CH;

    logic [drs_pkg::DIV_W-1:0] div_q;
    logic phase_q;
    logic [W-1:0] stage_q [N];
    logic [W-1:0] wr_buf_q [N];
    logic [2:0] wr_cnt_q;
    logic wr_busy_q;
    logic [W-1:0] rd_acc_q [N];
    logic [2:0] rd_cnt_q;
    logic rd_busy_q;
    logic [W-1:0] rx_cur [N];
    logic [W-1:0] rec_next [N];
    logic [W-1:0] stage_next [N];
    logic [drs_pkg::FRAME_W-1:0] rec_flat;
    logic [drs_pkg::FRAME_W-1:0] tx_flat;
    logic fifo_ready;
    logic fifo_valid;
    logic [W-1:0] fifo_rdata;
    logic [drs_pkg::LEVEL_W-1:0] fifo_level;
    logic [drs_pkg::LEVEL_W-1:0] fill_thr;
    logic [drs_pkg::DIV_W-1:0] period;
    logic [drs_pkg::FRAME_W-1:0] rx_frame_q;

    // Sample period and tick selection
    wire ds = i_double_rate_mode;
    wire resync = i_use_recovered && i_rx_frame_valid;
    assign period = ds ? (i_base_48k ? drs_pkg::PER_48_DS
                                     : drs_pkg::PER_441_DS)
                       : (i_base_48k ? drs_pkg::PER_48_SS
                                     : drs_pkg::PER_441_SS);
    wire tick = resync || (div_q == '0);
    // A resync tick always starts a new pair, whatever the old phase was
    wire cur_phase = !resync && phase_q;
    wire frame_tick = tick && (!ds || cur_phase);
    wire mux_done = frame_tick;
    wire fifo_push = wr_busy_q && fifo_ready;
    wire fifo_pop = rd_busy_q && fifo_valid;
    assign fill_thr = ds ? drs_pkg::FILL_DS : drs_pkg::FILL_SS;
    wire rd_go = frame_tick && !rd_busy_q && (fifo_level >= fill_thr);
    wire rd_last = fifo_pop && (rd_cnt_q == 3'(N - 1));
    wire wr_last = fifo_push && (wr_cnt_q == 3'(N - 1));

    // Demux, remux and frame assembly
    always_comb begin
        for (int c = 0; c < N; c++) begin
            rx_cur[c] = i_rx_frame_valid ? i_rx_frame[c*W +: W]
                                         : rx_frame_q[c*W +: W];
            rec_next[c] = '0;
            stage_next[c] = stage_q[c];
            tx_flat[c*W +: W] = rd_acc_q[c];
        end
        tx_flat[(N-1)*W +: W] = fifo_rdata;
        for (int k = 0; k < N; k++) begin
            if (!ds) begin
                rec_next[k] = rx_cur[k];
                stage_next[k] = rx_cur[k];
            end else if (k < drs_pkg::HR_CH) begin
                // Earlier sample on even slot, later on odd slot
                rec_next[k] = rx_cur[2*k + int'(cur_phase)];
                stage_next[2*k + int'(cur_phase)] = rec_next[k];
            end
        end
        for (int c = 0; c < N; c++) begin
            rec_flat[c*W +: W] = rec_next[c];
        end
    end

    // Last received link frame
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_frame_q <= '0;
        end else if (i_rx_frame_valid) begin
            rx_frame_q <= i_rx_frame;
        end
    end

    // Internal sample divider and frame phase
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_q <= '0;
            phase_q <= 1'b0;
        end else begin
            if (tick) div_q <= period - 1'b1;
            else div_q <= div_q - 1'b1;
            if (resync) phase_q <= ds;
            else if (tick) phase_q <= ds && !phase_q;
        end
    end

    // High-rate samples to the mixer side
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_sample_tick <= 1'b0;
            o_frame_tick <= 1'b0;
            o_rec_valid <= 1'b0;
            o_rec_data <= '0;
        end else begin
            o_sample_tick <= tick;
            o_frame_tick <= frame_tick;
            o_rec_valid <= tick;
            if (tick) o_rec_data <= rec_flat;
        end
    end

    // Pair gathering and fifo write sequencing
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int c = 0; c < N; c++) stage_q[c] <= '0;
            for (int c = 0; c < N; c++) wr_buf_q[c] <= '0;
            wr_cnt_q <= '0;
            wr_busy_q <= 1'b0;
            o_overrun <= 1'b0;
        end else begin
            if (tick) stage_q <= stage_next;
            if (mux_done && !wr_busy_q) begin
                wr_buf_q <= stage_next;
                wr_busy_q <= 1'b1;
                wr_cnt_q <= '0;
            end else if (wr_last) begin
                wr_busy_q <= 1'b0;
            end else if (fifo_push) begin
                wr_cnt_q <= wr_cnt_q + 1'b1;
            end
            // Frame lost while the previous one still drains
            if (mux_done && wr_busy_q) o_overrun <= 1'b1;
        end
    end

    // Delayed frame read and transmit
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int c = 0; c < N; c++) rd_acc_q[c] <= '0;
            rd_cnt_q <= '0;
            rd_busy_q <= 1'b0;
            o_tx_frame_valid <= 1'b0;
            o_tx_frame <= '0;
        end else begin
            o_tx_frame_valid <= rd_last;
            if (rd_go) begin
                rd_busy_q <= 1'b1;
                rd_cnt_q <= '0;
            end else if (rd_last) begin
                rd_busy_q <= 1'b0;
                o_tx_frame <= tx_flat;
            end else if (fifo_pop) begin
                rd_acc_q[rd_cnt_q] <= fifo_rdata;
                rd_cnt_q <= rd_cnt_q + 1'b1;
            end
        end
    end

    // Channel status byte 0 decode and build
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_cs_pro <= 1'b0;
            o_cs_nonaudio <= 1'b0;
            o_cs_emph <= '0;
            o_cs_copy <= 1'b0;
            o_cs_locked <= 1'b0;
            o_cs_hi <= '0;
            o_tx_cs_byte0 <= '0;
        end else begin
            if (i_cs_valid) begin
                o_cs_pro <= i_cs_byte0[drs_pkg::CS_PRO_BIT];
                o_cs_nonaudio <= i_cs_byte0[drs_pkg::CS_NONAUDIO_BIT];
                o_cs_hi <= i_cs_byte0[drs_pkg::CS_HI_LSB +: 2];
                if (i_cs_byte0[drs_pkg::CS_PRO_BIT]) begin
                    o_cs_emph <= i_cs_byte0[drs_pkg::CS_PRO_EMPH_LSB +: 3];
                    o_cs_copy <= 1'b0;
                    o_cs_locked <= i_cs_byte0[drs_pkg::CS_PRO_LOCK_BIT];
                end else begin
                    o_cs_emph <= i_cs_byte0[drs_pkg::CS_CON_EMPH_LSB +: 3];
                    o_cs_copy <= i_cs_byte0[drs_pkg::CS_CON_COPY_BIT];
                    o_cs_locked <= 1'b0;
                end
            end
            o_tx_cs_byte0 <= i_tx_pro
                ? {i_tx_hi, i_tx_copy, i_tx_emph, i_tx_nonaudio, 1'b1}
                : {i_tx_hi, i_tx_emph, i_tx_copy, i_tx_nonaudio, 1'b0};
        end
    end

    // Delay fifo between remux and transmitter
    drs_sample_fifo #(
        .WIDTH(drs_pkg::SAMPLE_W),
        .DEPTH(drs_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_wr_valid(wr_busy_q),
        .o_wr_ready(fifo_ready),
        .i_wr_data(wr_buf_q[wr_cnt_q]),
        .o_rd_valid(fifo_valid),
        .i_rd_ready(rd_busy_q),
        .o_rd_data(fifo_rdata),
        .o_level(fifo_level)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    chk_ss_delay_hold: assert property (
        (!ds && frame_tick && !rd_busy_q && fifo_level < drs_pkg::FILL_SS)
            |=> !rd_busy_q) else $error("frame read before 3 frames held");
    chk_ds_delay_read: assert property (
        (ds && rd_go) |-> fifo_level >= drs_pkg::FILL_DS ##9 o_tx_frame_valid)
        else $error("double-rate delayed frame not sent in time");
    chk_ds_tick_rate: assert property (
        (tick && ds && !resync && !i_base_48k)
            |=> div_q == drs_pkg::PER_441_DS - 1'b1)
        else $error("double-rate period not halved");
    chk_rec_width: assert property (
        (tick && !ds) |=> o_rec_data == $past(rec_flat))
        else $error("single-rate sample altered");
    chk_ds_upper_idle: assert property (
        (o_rec_valid && $past(ds)) |-> o_rec_data[191:96] == '0)
        else $error("more than four high-rate channels");
    chk_pair_order: assert property (
        (tick && ds && cur_phase) |=> stage_q[7] == $past(rx_cur[7]))
        else $error("later sample not on even link channel");
    chk_link_rate: assert property (
        (tick && ds && !phase_q) |-> !frame_tick)
        else $error("link frame at doubled rate");
    chk_cs_decode: assert property (
        (i_cs_valid && !i_cs_byte0[0]) |=>
            !o_cs_pro && o_cs_emph == $past(i_cs_byte0[5:3]))
        else $error("consumer byte misread");
    chk_pair_push: assert property (
        (mux_done && !wr_busy_q) |=> wr_busy_q && wr_cnt_q == 3'd0
            && wr_buf_q[0] == $past(stage_next[0]))
        else $error("gathered frame not queued");
endmodule // drs_sample_mux_top
`default_nettype wire

// File: rtl/drs_pkg.sv
// What this block does
// - Without double-rate mode the pass-through path from receiver to transmitter delays audio by three sample periods.
// - With double_rate_mode set the pass-through delay is six high-rate sample periods, on the path from receiver to transmitter only.
// - double_rate_mode doubles the internal sample tick, 44.1 kHz to 88.2 kHz and 48 kHz to 96 kHz.
// - Samples stay 24 bits wide in both single-rate and double-rate operation.
// - In double_rate_mode each high-rate channel rides on two link channels, so one eight-channel link carries four.
// - For high-rate channel k the earlier sample goes on link channel 2k-1 and the later one on link channel 2k.
// - While multiplexing, the link frame rate stays at the single-speed rate of 44.1 kHz or 48 kHz.
// - Bit 0 of channel-status byte 0 selects professional or consumer reading of the rest of that byte.
package drs_pkg;

    // ************************************************************
    // Widths and link layout
    // ************************************************************
    localparam int SAMPLE_W = 24;
    localparam int LINK_CH = 8;
    localparam int HR_CH = 4;
    localparam int FRAME_W = SAMPLE_W * LINK_CH;
    localparam int FIFO_DEPTH = 32;
    localparam int LEVEL_W = 6;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int RATE_441_HZ = 44_100;
    localparam int RATE_48_HZ = 48_000;
    localparam int DIV_W = 8;
    // Internal sample periods in core clock cycles, rounded down
    localparam logic [DIV_W-1:0] PER_441_SS = DIV_W'(CLK_HZ / RATE_441_HZ);
    localparam logic [DIV_W-1:0] PER_48_SS = DIV_W'(CLK_HZ / RATE_48_HZ);
    localparam logic [DIV_W-1:0] PER_441_DS =
        DIV_W'(CLK_HZ / (2 * RATE_441_HZ));
    localparam logic [DIV_W-1:0] PER_48_DS =
        DIV_W'(CLK_HZ / (2 * RATE_48_HZ));

    // ************************************************************
    // Pass-through delay
    // ************************************************************
    localparam int DELAY_SAMPLES_SS = 3;
    localparam int DELAY_SAMPLES_DS = 6;
    // Fifo fill, in words, that holds the delay in link frames
    localparam logic [LEVEL_W-1:0] FILL_SS =
        LEVEL_W'(DELAY_SAMPLES_SS * LINK_CH);
    localparam logic [LEVEL_W-1:0] FILL_DS =
        LEVEL_W'((DELAY_SAMPLES_DS / 2) * LINK_CH);

    // ************************************************************
    // Channel status byte 0 fields
    // ************************************************************
    localparam int CS_PRO_BIT = 0;
    localparam int CS_NONAUDIO_BIT = 1;
    localparam int CS_CON_COPY_BIT = 2;
    localparam int CS_PRO_EMPH_LSB = 2;
    localparam int CS_CON_EMPH_LSB = 3;
    localparam int CS_PRO_LOCK_BIT = 5;
    localparam int CS_HI_LSB = 6;

endpackage

// File: rtl/drs_sample_fifo.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// First-word-fall-through sample fifo
// ************************************************************
module drs_sample_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [WIDTH-1:0] o_rd_data,
    output logic [$clog2(DEPTH):0] o_level
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    wire push = i_wr_valid && o_wr_ready;
    wire pop = o_rd_valid && i_rd_ready;

    // Honest full and empty from the word count
    assign o_wr_ready = (cnt_q != FULL);
    assign o_rd_valid = (cnt_q != '0);
    assign o_rd_data = mem_q[rp_q];
    assign o_level = cnt_q;

    // Storage, no reset needed
    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem_q[wp_q] <= i_wr_data;
        end
    end

    // Pointers and count
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + 1'b1;
            if (pop) rp_q <= rp_q + 1'b1;
            if (push && !pop) cnt_q <= cnt_q + 1'b1;
            else if (pop && !push) cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule // drs_sample_fifo
`default_nettype wire

// File: verif/drs_far_end_model.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Far-end audio equipment: link frames and status byte 0
// ************************************************************
module drs_far_end_model (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [drs_pkg::DIV_W-1:0] i_period,
    output logic o_rx_frame_valid,
    output logic [drs_pkg::FRAME_W-1:0] o_rx_frame,
    output logic o_cs_valid,
    output logic [7:0] o_cs_byte0
);
    logic [drs_pkg::DIV_W-1:0] cnt_q;
    wire logic send = (cnt_q == '0);
    wire logic cs_send = (cnt_q == i_period / 2);

    // One frame per base period; idle lines show the inverse value
    always @(posedge i_core_clk or negedge i_rst_b) begin : gen
        logic [drs_pkg::FRAME_W-1:0] f;
        if (!i_rst_b) begin
            // First frame one period on, clear of the startup tick
            cnt_q <= drs_pkg::DIV_W'(1);
            o_rx_frame_valid <= 1'b0;
            o_rx_frame <= '0;
            o_cs_valid <= 1'b0;
            o_cs_byte0 <= '0;
        end else begin
            // Sample a on the odd link channel, b on the next one
            for (int i = 0; i < 6; i++) f[i*32 +: 32] = $urandom;
            o_rx_frame_valid <= send;
            o_rx_frame <= send ? f : ~o_rx_frame;
            o_cs_valid <= cs_send;
            // Bit 0 random, so both status readings occur
            o_cs_byte0 <= cs_send ? 8'($urandom) : ~o_cs_byte0;
            cnt_q <= (cnt_q == i_period - 1'b1) ? '0 : cnt_q + 1'b1;
        end
    end
endmodule // drs_far_end_model
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int FW = drs_pkg::FRAME_W;
    localparam int SW = drs_pkg::SAMPLE_W;
    logic i_core_clk, i_rst_b, ds, b48, rec, rxv, csv;
    logic [7:0] tx_in, cs, txb, s_cs, cs_last, s_tx;
    logic [drs_pkg::DIV_W-1:0] period, per_exp;
    logic [FW-1:0] rx, recd, txf, last_rx, s_rx;
    logic st, ft, recv, txv, ovr, pro, nau, copy, lck, s_rxv, s_csv;
    logic [2:0] emph;
    logic [1:0] hi;
    int fail_count, checked, cyc, ph, ftk, ntx, since, up, seen;
    logic [FW-1:0] expq[$];

    drs_far_end_model far (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_period(period), .o_rx_frame_valid(rxv), .o_rx_frame(rx),
        .o_cs_valid(csv), .o_cs_byte0(cs));
    drs_sample_mux_top uut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_double_rate_mode(ds), .i_base_48k(b48), .i_use_recovered(rec),
        .i_rx_frame_valid(rxv), .i_rx_frame(rx), .i_cs_valid(csv),
        .i_cs_byte0(cs), .i_tx_pro(tx_in[0]), .i_tx_nonaudio(tx_in[1]),
        .i_tx_emph(tx_in[4:2]), .i_tx_copy(tx_in[5]), .i_tx_hi(tx_in[7:6]),
        .o_sample_tick(st), .o_frame_tick(ft), .o_rec_valid(recv),
        .o_rec_data(recd), .o_tx_frame_valid(txv), .o_tx_frame(txf),
        .o_overrun(ovr), .o_cs_pro(pro), .o_cs_nonaudio(nau),
        .o_cs_emph(emph), .o_cs_copy(copy), .o_cs_locked(lck),
        .o_cs_hi(hi), .o_tx_cs_byte0(txb));

    // Compare helpers, one per kind of result
    task automatic bad(input logic [FW-1:0] g, input logic [FW-1:0] e);
        fail_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    endtask
    task automatic cmp_f(input logic [FW-1:0] g, input logic [FW-1:0] e);
        checked++;
        if (g !== e) bad(g, e);
    endtask
    task automatic cmp_b(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) bad(FW'(g), FW'(e));
    endtask
    task automatic cmp_n(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) bad(FW'(g), FW'(e));
    endtask
    task automatic test_done();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Expected high-rate samples: a at phase 0, b at phase 1
    function automatic logic [FW-1:0] exp_rec(input logic [FW-1:0] f,
        input int p);
        logic [FW-1:0] e;
        if (ds !== 1'b1) return f;
        e = '0;
        for (int k = 0; k < 4; k++) e[k*SW +: SW] = f[(2*k+p)*SW +: SW];
        return e;
    endfunction
    function automatic logic [8:0] dec(input logic [7:0] b);
        return {b[0], b[1], b[0] ? b[4:2] : b[5:3], ~b[0] & b[2],
            b[0] & b[5], b[7:6]};
    endfunction
    function automatic logic [7:0] enc(input logic [7:0] b);
        return b[0] ? {b[7:5], b[4:2], b[1], 1'b1}
            : {b[7:6], b[4:2], b[5], b[1], 1'b0};
    endfunction

    // Clock, transmit status inputs and hang guard
    always #50 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        tx_in <= 8'($urandom);
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
    end

    // Reference model, sampled where outputs are settled
    always @(negedge i_core_clk) begin
        if (!i_rst_b) begin
            // Phase 1 here makes the first free tick phase 0
            ph = 1; ftk = 0; ntx = 0; since = 0; seen = 0; up = 0;
            last_rx = '0; cs_last = '0; expq.delete();
        end else begin
            up++;
            since++;
            if (s_rxv) last_rx = s_rx;
            if (s_csv) cs_last = s_cs;
            cmp_b(16'(st), 16'(recv));
            if (recv === 1'b1) begin
                ph = s_rxv ? 0 : (ds ? 1 - ph : 0);
                cmp_f(recd, exp_rec(last_rx, ph));
            end
            cmp_b(16'(ft), 16'(recv === 1'b1 && (!ds || ph == 1)));
            if (st === 1'b1) begin
                if (seen) cmp_n(since, per_exp);
                since = 0;
                seen = 1;
            end
            if (ft === 1'b1) begin
                expq.push_back(last_rx);
                ftk++;
            end
            if (txv === 1'b1 && expq.size() > 0) begin
                cmp_n(ftk, ntx + 4);
                cmp_f(txf, expq.pop_front());
                ntx++;
            end
            cmp_b(16'({pro, nau, emph, copy, lck, hi}), 16'(dec(cs_last)));
            if (up > 2) cmp_b(16'(txb), 16'(enc(s_tx)));
        end
        s_rxv = rxv; s_rx = rx; s_csv = csv; s_cs = cs; s_tx = tx_in;
    end

    // Main sequence: all rate modes, then a mid-run reset of the delay
    initial begin
        i_core_clk = 0; i_rst_b = 0; ds = 0; b48 = 0; rec = 0; tx_in = 0;
        period = drs_pkg::PER_441_SS; per_exp = period;
        fail_count = 0; checked = 0; cyc = 0;
        void'($urandom(9));
        for (int m = 0; m < 4; m++) begin
            @(posedge i_core_clk);
            i_rst_b <= 0; ds <= m[0]; b48 <= m[1]; rec <= (m != 2);
            period <= m[1] ? drs_pkg::PER_48_SS : drs_pkg::PER_441_SS;
            per_exp <= m[0] ? (m[1] ? drs_pkg::PER_48_DS : drs_pkg::PER_441_DS)
                : (m[1] ? drs_pkg::PER_48_SS : drs_pkg::PER_441_SS);
            repeat (10) @(posedge i_core_clk);
            i_rst_b <= 1;
            repeat (2300) @(posedge i_core_clk);
            @(negedge i_core_clk);
            cmp_n(32'(ovr), 0);
            cmp_n(32'(ntx > 4), 1);
        end
        // Reset again in mid-run, still in the last rate mode: the delay fifo must prime again
        @(posedge i_core_clk);
        i_rst_b <= 0;
        repeat (10) @(posedge i_core_clk);
        i_rst_b <= 1;
        repeat (1500) begin
            @(negedge i_core_clk);
            if (txv === 1'b1) cmp_n(32'(ftk >= 4), 1);
            if (ftk < 3) cmp_b(16'(txv), 0);
        end
        cmp_n(32'(ovr), 0);
        cmp_n(32'(ntx > 2), 1);
        cmp_n(32'(expq.size() inside {3, 4}), 1);
        cmp_n(32'((ftk - ntx) inside {3, 4}), 1);
        test_done();
    end
endmodule // tb_top
`default_nettype wire
